// file: rtl/nic_pkg.sv
// Shared constants and carrier types of the interrupt controller.
// Assumes one 20 MHz core clock and a private register port driven by the core.
package nic_pkg;

  // ==========================================================================
  // Sizes
  localparam int NIC_NUM_IRQ    = 33;
  localparam int NIC_PRIO_W     = 4;
  localparam int NIC_ID_W       = 6;
  localparam int NIC_PRIO_WORDS = 9;
  localparam int NIC_LANE_W     = 8;
  localparam int NIC_LANES      = 4;
  localparam int NIC_IDX_W      = 4;
  localparam int NIC_SUB_W      = 3;

  // ==========================================================================
  // Register map, byte addresses on the private peripheral bus
  localparam logic [31:0] NIC_ISE_BASE   = 32'he000e100;
  localparam logic [31:0] NIC_ICE_BASE   = 32'he000e180;
  localparam logic [31:0] NIC_ISP_BASE   = 32'he000e200;
  localparam logic [31:0] NIC_ICP_BASE   = 32'he000e280;
  localparam logic [31:0] NIC_ACT_BASE   = 32'he000e300;
  localparam logic [31:0] NIC_IPA_BASE   = 32'he000e400;
  localparam logic [31:0] NIC_IPA_END    = 32'he000e424;
  localparam logic [31:0] NIC_TRIG_ADDR  = 32'he000ef00;
  localparam logic [31:0] NIC_WORD_STEP  = 32'h00000004;
  localparam logic [31:0] NIC_REG_RESET  = 32'h00000000;
  localparam logic [1:0]  NIC_ALIGN_ZERO = 2'h0;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic        sel;
    logic        write;
    logic        priv;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0]  be;
  } nic_bus_req_t;

  typedef struct packed {
    logic                  valid;
    logic [NIC_ID_W-1:0]   num;
    logic [NIC_PRIO_W-1:0] prio;
  } nic_irq_req_t;

endpackage : nic_pkg

// file: rtl/nic_prio_mem.sv
// Priority field store: one 4-bit field per interrupt, four fields per word.
// Assumes the caller has already checked privilege and address range.
`timescale 1ns/10ps
module nic_prio_mem
  import nic_pkg::*;
#(
  parameter int NUM = NIC_NUM_IRQ,
  parameter int W   = NIC_PRIO_W
) (
  input  wire logic                 sys_clk,
  input  wire logic                 arst_n,
  input  wire logic                 wr_en,
  input  wire logic [NIC_IDX_W-1:0] wr_idx,
  input  wire logic [3:0]           wr_be,
  input  wire logic [31:0]          wr_data,
  input  wire logic [NIC_IDX_W-1:0] rd_idx,
  output logic      [31:0]          rd_data_q,
  output logic      [NUM*W-1:0]     prio_flat
);

  logic [31:0] rd_data_d;

  // ==========================================================================
  // Fields, each written through its own byte lane
  for (genvar i = 0; i < NUM; i++) begin : g_field
    logic [W-1:0] field_q;
    logic [W-1:0] field_d;
    always_comb begin
      field_d = field_q;
      if (wr_en && (wr_idx == NIC_IDX_W'(i / NIC_LANES)) && wr_be[i % NIC_LANES]) begin
        field_d = wr_data[(i % NIC_LANES) * NIC_LANE_W +: W];
      end
    end
    always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
        field_q <= '0;
      end else begin
        field_q <= field_d;
      end
    end
    assign prio_flat[i*W +: W] = field_q;
  end

  // ==========================================================================
  // Registered read port; unused lanes and upper nibbles read as zero
  always_comb begin
    rd_data_d = NIC_REG_RESET;
    for (int j = 0; j < NIC_LANES; j++) begin
      if ((int'(rd_idx) * NIC_LANES + j) < NUM) begin
        rd_data_d[j*NIC_LANE_W +: W] = prio_flat[(int'(rd_idx) * NIC_LANES + j) * W +: W];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data_q <= NIC_REG_RESET;
    end else begin
      rd_data_q <= rd_data_d;
    end
  end

endmodule : nic_prio_mem

// file: rtl/nic_top.sv
// Interrupt controller: enable, pending and active state, priority arbitration.
// Assumes the core acknowledges the presented request and reports handler exit.
`timescale 1ns/10ps
module nic_top
  import nic_pkg::*;
#(
  parameter int NUM_IRQ = NIC_NUM_IRQ
) (
  input  wire logic                sys_clk,
  input  wire logic                arst_n,
  input  wire logic [NUM_IRQ-1:0]  irq_in,
  input  wire nic_bus_req_t        bus_req,
  input  wire logic                trig_unpriv_en,
  input  wire logic [NIC_SUB_W-1:0] sub_bits,
  input  wire logic                core_ack,
  input  wire logic                core_exit,
  input  wire logic [NIC_ID_W-1:0] core_exit_num,
  output logic      [31:0]         bus_rdata_q,
  output logic                     bus_rvalid_q,
  output logic                     bus_fault_q,
  output nic_irq_req_t             irq_out_q
);

  localparam logic [NUM_IRQ-1:0] ONE = NUM_IRQ'(1);

  // ==========================================================================
  // Input synchronisers: a level is accepted once stages two and three agree
  logic [NUM_IRQ-1:0] s1_q, s2_q, s3_q, lvl_q, lvl_d, rise;

  always_comb begin
    lvl_d = (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
    rise  = lvl_d & ~lvl_q;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      lvl_q <= '0;
    end else begin
      s1_q  <= irq_in;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  // ==========================================================================
  // Register port decode
  logic               acc_ok, wr_ok, rd_ok, hi_word, trig_ok, ipa_hit, mapped;
  logic               hit_ise, hit_ice, hit_isp, hit_icp, hit_act;
  logic [31:0]        wmask, ipa_off;
  logic [NUM_IRQ-1:0] wbits, trig_vec;
  logic [63:0]        wide;

  function automatic logic grp_hit(input logic [31:0] a, input logic [31:0] base);
    return (a == base) || (a == base + NIC_WORD_STEP);
  endfunction : grp_hit

  function automatic logic [31:0] word_of(input logic [NUM_IRQ-1:0] v, input logic hi);
    logic [63:0] w;
    w = {{(64-NUM_IRQ){1'b0}}, v};
    return hi ? w[63:32] : w[31:0];
  endfunction : word_of

  always_comb begin
    acc_ok  = bus_req.sel && bus_req.priv;
    wr_ok   = acc_ok && bus_req.write;
    rd_ok   = acc_ok && !bus_req.write;
    hi_word = bus_req.addr[2];
    hit_ise = grp_hit(bus_req.addr, NIC_ISE_BASE);
    hit_ice = grp_hit(bus_req.addr, NIC_ICE_BASE);
    hit_isp = grp_hit(bus_req.addr, NIC_ISP_BASE);
    hit_icp = grp_hit(bus_req.addr, NIC_ICP_BASE);
    hit_act = grp_hit(bus_req.addr, NIC_ACT_BASE);
    ipa_off = bus_req.addr - NIC_IPA_BASE;
    ipa_hit = (bus_req.addr >= NIC_IPA_BASE) && (bus_req.addr < NIC_IPA_END)
              && (bus_req.addr[1:0] == NIC_ALIGN_ZERO);
    mapped  = hit_ise || hit_ice || hit_isp || hit_icp || hit_act || ipa_hit;
    wmask   = bus_req.wdata & {{8{bus_req.be[3]}}, {8{bus_req.be[2]}},
                               {8{bus_req.be[1]}}, {8{bus_req.be[0]}}};
    wide    = hi_word ? {wmask, 32'h00000000} : {32'h00000000, wmask};
    wbits   = wide[NUM_IRQ-1:0];
    // Software trigger may be opened to unprivileged code by trig_unpriv_en.
    trig_ok = bus_req.sel && bus_req.write && (bus_req.addr == NIC_TRIG_ADDR)
              && (bus_req.priv || trig_unpriv_en);
    trig_vec = '0;
    if (trig_ok && (int'(bus_req.wdata[NIC_ID_W-1:0]) < NUM_IRQ)) begin
      trig_vec = ONE << bus_req.wdata[NIC_ID_W-1:0];
    end
  end

  // ==========================================================================
  // Enable, pending and active state
  logic [NUM_IRQ-1:0] en_q, en_d, pend_q, pend_d, act_q, act_d;
  logic [NUM_IRQ-1:0] ack_vec, exit_vec, hw_set, en_set, en_clr, sw_set, sw_clr;
  logic               take;

  always_comb begin
    take     = core_ack && irq_out_q.valid;
    ack_vec  = take ? (ONE << irq_out_q.num) : '0;
    exit_vec = core_exit ? (ONE << core_exit_num) : '0;
    en_set   = (wr_ok && hit_ise) ? wbits : '0;
    en_clr   = (wr_ok && hit_ice) ? wbits : '0;
    sw_set   = (wr_ok && hit_isp) ? wbits : '0;
    sw_clr   = (wr_ok && hit_icp) ? wbits : '0;
    // A held level re-pends only while the interrupt is not being serviced.
    hw_set   = rise | (lvl_q & ~act_q & ~ack_vec);
    en_d     = (en_q | en_set) & ~en_clr;
    // New events win over a clear arriving in the same cycle.
    pend_d   = (pend_q & ~sw_clr & ~ack_vec) | hw_set | sw_set | trig_vec;
    act_d    = (act_q | ack_vec) & ~exit_vec;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      en_q   <= '0;
      pend_q <= '0;
      act_q  <= '0;
    end else begin
      en_q   <= en_d;
      pend_q <= pend_d;
      act_q  <= act_d;
    end
  end

  // ==========================================================================
  // Priority store
  logic [NUM_IRQ*NIC_PRIO_W-1:0] prio_flat;
  logic [31:0]                   prio_rd;

  nic_prio_mem #(
    .NUM (NUM_IRQ),
    .W   (NIC_PRIO_W)
  ) nic_prio_mem_inst (
    .sys_clk   (sys_clk),
    .arst_n    (arst_n),
    .wr_en     (wr_ok && ipa_hit),
    .wr_idx    (ipa_off[NIC_IDX_W+1:2]),
    .wr_be     (bus_req.be),
    .wr_data   (bus_req.wdata),
    .rd_idx    (ipa_off[NIC_IDX_W+1:2]),
    .rd_data_q (prio_rd),
    .prio_flat (prio_flat)
  );

  // ==========================================================================
  // Arbitration: priorities are read live from the store every cycle
  logic                  best_ok, any_act, preempt;
  logic [NIC_ID_W-1:0]   best_num;
  logic [NIC_PRIO_W-1:0] best_prio, run_grp, p;
  nic_irq_req_t          irq_out_d;

  always_comb begin
    best_ok   = 1'b0;
    best_num  = '0;
    best_prio = '0;
    any_act   = 1'b0;
    run_grp   = '0;
    p         = '0;
    for (int i = 0; i < NUM_IRQ; i++) begin
      p = prio_flat[i*NIC_PRIO_W +: NIC_PRIO_W];
      // Strict compare keeps the lowest number among equal priorities.
      if (pend_q[i] && en_q[i] && !act_q[i] && (!best_ok || (p < best_prio))) begin
        best_ok   = 1'b1;
        best_num  = NIC_ID_W'(i);
        best_prio = p;
      end
      if (act_q[i] && (!any_act || ((p >> sub_bits) < run_grp))) begin
        any_act = 1'b1;
        run_grp = p >> sub_bits;
      end
    end
    // Only a strictly more urgent group may interrupt a running handler.
    preempt         = best_ok && (!any_act || ((best_prio >> sub_bits) < run_grp));
    irq_out_d.valid = preempt && !take;
    irq_out_d.num   = best_num;
    irq_out_d.prio  = best_prio;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_out_q <= '0;
    end else begin
      irq_out_q <= irq_out_d;
    end
  end

  // ==========================================================================
  // Read path: two cycles, so priority words can come from the store's register
  logic        rd_s1_q, rd_s1_d, rd_prio_q, rd_prio_d, fault_d;
  logic [31:0] rd_word_q, rd_word_d, rdata_d;

  always_comb begin
    rd_s1_d   = bus_req.sel && !bus_req.write;
    rd_prio_d = rd_ok && ipa_hit;
    rd_word_d = NIC_REG_RESET;
    if (rd_ok && (hit_ise || hit_ice)) begin
      rd_word_d = word_of(en_q, hi_word);
    end else if (rd_ok && (hit_isp || hit_icp)) begin
      rd_word_d = word_of(pend_q, hi_word);
    end else if (rd_ok && hit_act) begin
      rd_word_d = word_of(act_q, hi_word);
    end
    fault_d = bus_req.sel && !trig_ok && (!bus_req.priv || !mapped);
    rdata_d = rd_prio_q ? prio_rd : rd_word_q;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_s1_q      <= 1'b0;
      rd_prio_q    <= 1'b0;
      rd_word_q    <= NIC_REG_RESET;
      bus_rdata_q  <= NIC_REG_RESET;
      bus_rvalid_q <= 1'b0;
      bus_fault_q  <= 1'b0;
    end else begin
      rd_s1_q      <= rd_s1_d;
      rd_prio_q    <= rd_prio_d;
      rd_word_q    <= rd_word_d;
      bus_rdata_q  <= rdata_d;
      bus_rvalid_q <= rd_s1_q;
      bus_fault_q  <= fault_d;
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  AST_EN_SET: assert property (wr_ok && hit_ise
                               |=> (en_q & $past(wbits)) == $past(wbits))
    else $error("enable-set write did not enable its interrupts");
  AST_EN_CLR: assert property (wr_ok && hit_ice |=> (en_q & $past(wbits)) == '0)
    else $error("enable-clear write did not disable its interrupts");
  AST_PEND_SET: assert property (wr_ok && hit_isp
                                 |=> (pend_q & $past(wbits)) == $past(wbits))
    else $error("pending-set write did not pend its interrupts");
  AST_PCLR_ACTIVE: assert property (wr_ok && hit_icp && !core_ack && !core_exit
                                    |=> act_q == $past(act_q))
    else $error("pending-clear changed the active state");
  AST_DISABLED_QUIET: assert property (en_q == '0 |=> !irq_out_q.valid)
    else $error("request raised with every interrupt disabled");
  // Any input rising while its interrupt is disabled must still reach pending.
  AST_PEND_DISABLED: assert property ((rise & ~en_q) != '0
                                      |=> (pend_q & $past(rise & ~en_q)) == $past(rise & ~en_q))
    else $error("disabled interrupt input did not pend");
  // An opened trigger write is legal without privilege, so it is left out here.
  AST_UNPRIV_IGNORED: assert property (bus_req.sel && !bus_req.priv && bus_req.write
                                       && !trig_ok
                                       |=> en_q == $past(en_q) ##0 bus_fault_q)
    else $error("unprivileged write changed enables or gave no fault");
  // The read word is the active state as it stood at the edge that took the read.
  AST_ACT_READ: assert property (rd_ok && hit_act && !hi_word
                                 |=> ##1 bus_rvalid_q
                                 && bus_rdata_q == word_of($past(act_q, 2), 1'b0))
    else $error("active-flag read returned the wrong word");
  AST_ACK_ENTRY: assert property (take
                                  |=> act_q[$past(irq_out_q.num)] && !irq_out_q.valid)
    else $error("acknowledged interrupt not made active");

  COV_REQ: cover property (irq_out_q.valid);
  COV_PREEMPT: cover property (irq_out_q.valid && act_q != '0);
  COV_SUBPRIO: cover property (irq_out_q.valid && act_q != '0 && sub_bits != '0);
  COV_ACK_EXIT: cover property (take ##[1:60] core_exit);

endmodule : nic_top

// file: dv/nic_core_model.sv
// Behavioural model of the core's exception logic facing the controller.
// Assumes the bench steers acceptance, acceptance delay and handler exits.
`timescale 1ns/10ps
module nic_core_model
  import nic_pkg::*;
(
  input  wire logic                sys_clk,
  input  wire logic                arst_n,
  input  wire nic_irq_req_t        irq_out,
  input  wire logic                ack_en,
  input  wire logic [3:0]          ack_wait,
  input  wire logic                exit_go,
  input  wire logic [NIC_ID_W-1:0] exit_id,
  output logic                     core_ack,
  output logic                     core_exit,
  output logic      [NIC_ID_W-1:0] core_exit_num
);
  logic [3:0] wait_q;
  // Exits come straight from exit_go and exit_id, whether or not a request was taken.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wait_q        <= 4'h0;
      core_ack      <= 1'b0;
      core_exit     <= 1'b0;
      core_exit_num <= '0;
    end else begin
      core_ack  <= 1'b0;
      wait_q    <= 4'h0;
      core_exit <= exit_go;
      // A released number line never keeps its last value.
      core_exit_num <= exit_go ? exit_id : ~core_exit_num;
      if (irq_out.valid && ack_en && !core_ack) begin
        if (wait_q == ack_wait) core_ack <= 1'b1;
        else wait_q <= wait_q + 4'h1;
      end
    end
  end
endmodule : nic_core_model

// file: dv/nested_vectored_interrupt_ctrl_bench.sv
// Self-checking bench for the interrupt controller and its core model.
// Assumes nic_top with 33 inputs; stimulus changes at falling edges.
`timescale 1ns/10ps
module nested_vectored_interrupt_ctrl_bench import nic_pkg::*;;
  logic                   sys_clk = 1'b0;
  logic                   arst_n = 1'b0;
  logic [NIC_NUM_IRQ-1:0] irq_in = '0;
  nic_bus_req_t           bus_req = '0;
  logic                   trig_unpriv_en = 1'b0;
  logic [NIC_SUB_W-1:0]   sub_bits = '0;
  logic                   core_ack, core_exit, ack_en = 1'b0, exit_go = 1'b0;
  logic [NIC_ID_W-1:0]    core_exit_num, exit_id = '0;
  logic [3:0]             ack_wait = 4'h3;
  logic [31:0]            bus_rdata_q, rd;
  logic                   bus_rvalid_q, bus_fault_q, flt;
  nic_irq_req_t           irq_out_q;
  int                     n_mismatch = 0;
  int                     checked = 0;
  always #25 sys_clk = ~sys_clk;
  nic_top nic_top_inst (.sys_clk(sys_clk), .arst_n(arst_n), .irq_in(irq_in),
    .bus_req(bus_req), .trig_unpriv_en(trig_unpriv_en), .sub_bits(sub_bits),
    .core_ack(core_ack), .core_exit(core_exit), .core_exit_num(core_exit_num),
    .bus_rdata_q(bus_rdata_q), .bus_rvalid_q(bus_rvalid_q),
    .bus_fault_q(bus_fault_q), .irq_out_q(irq_out_q));
  nic_core_model nic_core_model_inst (.sys_clk(sys_clk), .arst_n(arst_n),
    .irq_out(irq_out_q), .ack_en(ack_en), .ack_wait(ack_wait), .exit_go(exit_go),
    .exit_id(exit_id), .core_ack(core_ack), .core_exit(core_exit),
    .core_exit_num(core_exit_num));
  // ==========================================================================
  // Shared tasks
  task automatic end_of_test();
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc
  // One access; fault is sampled one cycle and read data two cycles after the take.
  task automatic acc(input logic w, input logic p, input logic [31:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    @(negedge sys_clk);
    bus_req = '{sel: 1'b1, write: w, priv: p, addr: a, wdata: d, be: be};
    @(negedge sys_clk);
    bus_req.sel = 1'b0;
    flt = bus_fault_q;
    @(negedge sys_clk);
    rd = bus_rdata_q;
    if (!w) chk({31'h0, bus_rvalid_q}, 32'h00000001);
  endtask : acc
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    acc(1'b1, 1'b1, a, d, 4'hf);
  endtask : wr
  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    acc(1'b0, 1'b1, a, 32'h0, 4'h0);
    chk(rd, exp);
    chk({31'h0, flt}, 32'h0);
  endtask : rdc
  task automatic irq_is(input logic v, input logic [5:0] n, input logic [3:0] p);
    chk({21'h0, irq_out_q}, {21'h0, v, n, p});
  endtask : irq_is
  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    irq_is(1'b0, 6'h00, 4'h0);
    rdc(NIC_ISE_BASE, 32'h0);
    rdc(NIC_ICE_BASE + 32'h4, 32'h0);
    rdc(NIC_ISP_BASE, 32'h0);
    rdc(NIC_ACT_BASE, 32'h0);
    for (int i = 0; i < NIC_PRIO_WORDS; i++) rdc(NIC_IPA_BASE + 4 * i, 32'h0);
  endtask : t_reset
  task automatic t_enable();
    wr(NIC_ISE_BASE, 32'h80000001);
    wr(NIC_ISE_BASE + 32'h4, 32'h00000001);
    wr(NIC_ISE_BASE, 32'h0);
    rdc(NIC_ISE_BASE, 32'h80000001);
    rdc(NIC_ICE_BASE, 32'h80000001);
    rdc(NIC_ICE_BASE + 32'h4, 32'h00000001);
    wr(NIC_ICE_BASE, 32'h00000001);
    rdc(NIC_ISE_BASE, 32'h80000000);
    wr(NIC_ICE_BASE, 32'h80000000);
    wr(NIC_ICE_BASE + 32'h4, 32'h00000001);
    rdc(NIC_ISE_BASE + 32'h4, 32'h0);
  endtask : t_enable
  task automatic t_prio();
    acc(1'b1, 1'b1, NIC_IPA_BASE, 32'hffffffff, 4'h2);
    rdc(NIC_IPA_BASE, 32'h00000f00);
    wr(NIC_IPA_BASE + 32'h20, 32'hffffffff);
    rdc(NIC_IPA_BASE + 32'h20, 32'h0000000f);
    wr(NIC_IPA_BASE, 32'h0);
    wr(NIC_IPA_BASE + 32'h20, 32'h0);
  endtask : t_prio
  task automatic t_pend();
    wr(NIC_IPA_BASE, 32'h02000000);
    wr(NIC_IPA_BASE + 32'h4, 32'h02000000);
    wr(NIC_ISP_BASE, 32'h00000088);
    cyc(2);
    irq_is(1'b0, 6'h00, 4'h0);
    wr(NIC_ISP_BASE, 32'h00000088);
    rdc(NIC_ICP_BASE, 32'h00000088);
    wr(NIC_ISE_BASE, 32'h00000080);
    cyc(2);
    irq_is(1'b1, 6'h07, 4'h2);
    wr(NIC_ISE_BASE, 32'h00000008);
    cyc(2);
    irq_is(1'b1, 6'h03, 4'h2);
    acc(1'b1, 1'b1, NIC_IPA_BASE + 32'h4, 32'h01000000, 4'h8);
    cyc(2);
    irq_is(1'b1, 6'h07, 4'h1);
    wr(NIC_ICP_BASE, 32'h00000088);
    cyc(2);
    irq_is(1'b0, 6'h00, 4'h0);
    wr(NIC_ICE_BASE, 32'h00000088);
  endtask : t_pend
  task automatic t_active();
    wr(NIC_ISE_BASE, 32'h00000600);
    ack_en = 1'b1;
    irq_in[9] = 1'b1;
    cyc(12);
    irq_in[9] = 1'b0;
    ack_en = 1'b0;
    rdc(NIC_ACT_BASE, 32'h00000200);
    wr(NIC_ICP_BASE, 32'h00000200);
    rdc(NIC_ACT_BASE, 32'h00000200);
    exit_id = 6'h09;
    exit_go = 1'b1;
    cyc(1);
    exit_go = 1'b0;
    cyc(3);
    rdc(NIC_ACT_BASE, 32'h0);
    irq_in[10] = 1'b1;
    cyc(2);
    irq_in[10] = 1'b0;
    cyc(4);
    rdc(NIC_ISP_BASE, 32'h00000400);
    wr(NIC_ICP_BASE, 32'h00000400);
    wr(NIC_ICE_BASE, 32'h00000600);
    // A held level on a disabled line must pend but never be presented.
    irq_in[20] = 1'b1;
    cyc(6);
    chk({31'h0, irq_out_q.valid}, 32'h0);
    rdc(NIC_ISP_BASE, 32'h00100000);
    irq_in[20] = 1'b0;
    cyc(5);
    wr(NIC_ICP_BASE, 32'h00100000);
    rdc(NIC_ISP_BASE, 32'h0);
  endtask : t_active
  task automatic t_priv();
    acc(1'b0, 1'b0, NIC_ISE_BASE, 32'h0, 4'h0);
    chk({31'h0, flt}, 32'h00000001);
    chk(rd, 32'h0);
    acc(1'b1, 1'b0, NIC_ISE_BASE, 32'h00000001, 4'hf);
    chk({31'h0, flt}, 32'h00000001);
    rdc(NIC_ISE_BASE, 32'h0);
    acc(1'b0, 1'b1, 32'he000e500, 32'h0, 4'h0);
    chk({31'h0, flt}, 32'h00000001);
    chk(rd, 32'h0);
    trig_unpriv_en = 1'b1;
    acc(1'b1, 1'b0, NIC_TRIG_ADDR, 32'h00000004, 4'hf);
    chk({31'h0, flt}, 32'h0);
    trig_unpriv_en = 1'b0;
    acc(1'b1, 1'b0, NIC_TRIG_ADDR, 32'h00000005, 4'hf);
    chk({31'h0, flt}, 32'h00000001);
    rdc(NIC_ISP_BASE, 32'h00000010);
    wr(NIC_ICP_BASE, 32'h00000010);
  endtask : t_priv
  // Fields 12, 13 and 14 hold 4, 5 and 2; with one subpriority bit the groups are 2, 2, 1.
  task automatic t_nest();
    wr(NIC_IPA_BASE + 32'hc, 32'h00020504);
    sub_bits = 3'h1;
    wr(NIC_ISE_BASE, 32'h00007000);
    wr(NIC_ISP_BASE, 32'h00002000);
    irq_is(1'b1, 6'h0d, 4'h5);
    ack_en = 1'b1;
    cyc(8);
    ack_en = 1'b0;
    rdc(NIC_ACT_BASE, 32'h00002000);
    wr(NIC_ISP_BASE, 32'h00001000);
    cyc(2);
    chk({31'h0, irq_out_q.valid}, 32'h0);
    wr(NIC_ISP_BASE, 32'h00004000);
    cyc(2);
    irq_is(1'b1, 6'h0e, 4'h2);
    sub_bits = 3'h4;
    cyc(2);
    chk({31'h0, irq_out_q.valid}, 32'h0);
    sub_bits = 3'h0;
    exit_id = 6'h0d;
    exit_go = 1'b1;
    cyc(1);
    exit_go = 1'b0;
    cyc(3);
    irq_is(1'b1, 6'h0e, 4'h2);
    rdc(NIC_ACT_BASE, 32'h0);
    wr(NIC_ICE_BASE, 32'h00007000);
    wr(NIC_ICP_BASE, 32'h00005000);
    wr(NIC_IPA_BASE + 32'hc, 32'h0);
  endtask : t_nest
  // ==========================================================================
  // Sequence and watchdog
  initial begin
    repeat (20) @(negedge sys_clk);
    arst_n = 1'b1;
    t_reset();
    t_enable();
    t_prio();
    t_pend();
    t_active();
    t_priv();
    t_nest();
    end_of_test();
  end
  initial begin
    repeat (4000) @(posedge sys_clk);
    n_mismatch++;
    end_of_test();
  end
endmodule : nested_vectored_interrupt_ctrl_bench
